// *** aux_diag_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
module aux_diag_decode
   import balance_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Selector and port roles.
   input wire logic [2:0] aux_diag_select,
   input wire logic [5:0] aux_port_analog,
   // Diagnostic controls.
   output logic [5:0] aux_discharge_r,
   output logic therm_to_ground_r
);

   logic [5:0] aux_discharge_nxt;
   logic therm_to_ground_nxt;

   // Codes 00x and 1xx leave the ports in normal operation.
   assign aux_discharge_nxt = (aux_diag_select == AUX_ACCEL_DISCHARGE) ?
                              aux_port_analog : 6'h00;
   assign therm_to_ground_nxt = (aux_diag_select == AUX_THERM_GROUND);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_discharge_r <= 6'h00;
         therm_to_ground_r <= 1'b0;
      end else if (clk_en) begin
         aux_discharge_r <= aux_discharge_nxt;
         therm_to_ground_r <= therm_to_ground_nxt;
      end
   end

endmodule
`default_nettype wire

// *** balance_pkg.sv ***
package balance_pkg;

   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_AUX_DIAG = 8'h6e;
   localparam logic [7:0] IDX_SWITCH = 8'h6f;
   localparam logic [7:0] IDX_EXP_GROUP = 8'h70;
   localparam logic [7:0] IDX_EXP_CELL_TWO = 8'h71;
   localparam logic [11:0] ADDR_AUX_DIAG = {2'h0, IDX_AUX_DIAG, 2'h0};
   localparam logic [11:0] ADDR_SWITCH = {2'h0, IDX_SWITCH, 2'h0};
   localparam logic [11:0] ADDR_EXP_GROUP = {2'h0, IDX_EXP_GROUP, 2'h0};
   localparam logic [11:0] ADDR_EXP_CELL_TWO = {2'h0, IDX_EXP_CELL_TWO, 2'h0};

   // Field layout.
   localparam int AUX_SEL_LSB = 13;
   localparam int RESTART_BIT = 15;
   localparam logic [15:0] MASK_AUX_DIAG = 16'he000;
   localparam logic [15:0] MASK_SWITCH = 16'h3fff;
   localparam logic [15:0] MASK_EXPIRY = 16'h03ff;

   // Reset values.
   localparam logic [2:0] RST_AUX_SEL = 3'h0;
   localparam logic [13:0] RST_SWITCH_EN = 14'h0000;
   localparam logic [9:0] RST_EXPIRY = 10'h000;

   // Balancing modes seen on the balance_mode input.
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_DISCHARGE = 3'h1;
   localparam logic [2:0] MODE_MANUAL = 3'h2;
   localparam logic [2:0] MODE_GROUP = 3'h3;

   // Auxiliary diagnostic selector codes.
   localparam logic [2:0] AUX_ACCEL_DISCHARGE = 3'h2;
   localparam logic [2:0] AUX_THERM_GROUND = 3'h3;

   // Special expiry values.
   localparam logic [9:0] EXP_FOREVER = 10'h3ff;
   localparam logic [9:0] EXP_NONE = 10'h000;

   typedef enum logic [1:0] {UNIT_SECOND, UNIT_MINUTE, UNIT_HOUR} unit_e;

   function automatic unit_e unit_of_mode(input logic [2:0] mode);
      if (mode == MODE_MANUAL) begin
         return UNIT_SECOND;
      end else if (mode[2]) begin
         return UNIT_HOUR;
      end else begin
         return UNIT_MINUTE;
      end
   endfunction

   function automatic logic is_expired(input logic [9:0] limit, input logic [9:0] count);
      if (limit == EXP_NONE) begin
         return 1'b1;
      end else if (limit == EXP_FOREVER) begin
         return 1'b0;
      end else begin
         return count >= limit;
      end
   endfunction

   // Merges write data into a 16-bit register honouring the two low byte strobes.
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [1:0] strb, input logic [15:0] mask);
      logic [15:0] lanes;
      lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
      return (old & ~lanes) | (wd & lanes);
   endfunction

endpackage

// *** balance_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module balance_timer
   import balance_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Control.
   input wire logic [2:0] mode,
   input wire logic [9:0] limit,
   input wire logic arm,
   input wire logic restart,
   // Time base pulses.
   input wire logic tick_second,
   input wire logic tick_minute,
   input wire logic tick_hour,
   // State.
   output logic [9:0] count_r,
   output logic expired_r
);

   unit_e unit;
   logic tick;
   logic [9:0] count_nxt;
   logic expired_nxt;

   assign unit = unit_of_mode(mode);
   assign tick = (unit == UNIT_SECOND) ? tick_second :
                 (unit == UNIT_MINUTE) ? tick_minute : tick_hour;

   // An expired timer ignores a restart; only a fresh arm starts it again.
   assign count_nxt = arm ? 10'h000 :
                      (restart && !expired_r) ? 10'h000 :
                      (tick && !expired_r && mode != MODE_OFF && count_r != EXP_FOREVER) ?
                      count_r + 10'h001 : count_r;
   assign expired_nxt = is_expired(limit, count_nxt) || (expired_r && !arm);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= 10'h000;
         expired_r <= 1'b1;
      end else if (clk_en) begin
         count_r <= count_nxt;
         expired_r <= expired_nxt;
      end
   end

endmodule
`default_nettype wire

// *** balance_timer_registers.sv ***
// Summary of operation
// - Selector 00x normal, 010 accelerated discharge, 011 thermistor to ground, 1xx reserved.
// - Switch control writes are ignored in balancing mode 001 or 1xx.
// - Writing 1 to bit 15 clears the timer; the strobe reads 0.
// - The restart strobe acts only in manual balancing mode.
// - After expiry restart is ignored; rewrite balancing control to start again.
// - Enable bit n closes the switch across cell n in manual mode until the watchdog expires.
// - Group expiry writes are ignored unless balancing mode is 000.
// - Group expiry is the timeout for manual, discharge and group modes.
// - Expiry is 10 bits; LSB weight is hour, minute or second by mode.
// - Expiry 0x3ff keeps balancing active forever.
// - Expiry 0x000, the reset value, counts as already expired.
// - Cell two expiry applies only in individual automated modes.
// - Cell two expiry writes are ignored in any 1xx mode.
`timescale 1ns/10ps
`default_nettype none
module balance_timer_registers
   import balance_pkg::*;
(
   // APB slave.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Balancing context.
   input wire logic [2:0] balance_mode,
   input wire logic balance_control_write,
   input wire logic tick_second,
   input wire logic tick_minute,
   input wire logic tick_hour,
   // Auxiliary port roles.
   input wire logic [5:0] aux_port_analog,
   // Switch and timer outputs.
   output logic [13:0] switch_close,
   output logic balance_timer_expired,
   output logic [9:0] balance_timer,
   output logic [9:0] group_limit,
   output logic [9:0] cell_two_limit,
   // Auxiliary diagnostics.
   output logic [5:0] aux_discharge,
   output logic therm_to_ground
);

   ////////////////////////////////////////////////////////////////////////////////
   logic [2:0] aux_diag_select_r;
   logic [13:0] balance_switch_enable_r;
   logic [9:0] group_expiry_time_r;
   logic [9:0] cell_two_expiry_time_r;
   logic [31:0] prdata_r;
   logic [31:0] read_val;
   logic [15:0] wd16;
   logic [1:0] strb16;
   logic [15:0] aux_word;
   logic [15:0] switch_word;
   logic [15:0] group_word;
   logic [15:0] cell_two_word;
   logic [15:0] aux_merge;
   logic [15:0] switch_merge;
   logic [15:0] group_merge;
   logic [15:0] cell_two_merge;
   logic [9:0] timer_count;
   logic timer_expired;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode.
   wire hit_aux = (paddr == ADDR_AUX_DIAG);
   wire hit_switch = (paddr == ADDR_SWITCH);
   wire hit_group = (paddr == ADDR_EXP_GROUP);
   wire hit_cell_two = (paddr == ADDR_EXP_CELL_TWO);
   wire hit_any = hit_aux || hit_switch || hit_group || hit_cell_two;
   wire access = psel && penable;
   wire wr_fire = access && pwrite && hit_any;
   wire rd_setup = psel && !penable && !pwrite;

   // Write guards by balancing mode.
   wire mode_auto = balance_mode[2];
   wire switch_wr_ok = !(balance_mode == MODE_DISCHARGE || mode_auto);
   wire group_wr_ok = (balance_mode == MODE_OFF);
   wire cell_two_wr_ok = !mode_auto;
   wire mode_manual = (balance_mode == MODE_MANUAL);

   wire wr_aux = wr_fire && hit_aux;
   wire wr_switch = wr_fire && hit_switch && switch_wr_ok;
   wire wr_group = wr_fire && hit_group && group_wr_ok;
   wire wr_cell_two = wr_fire && hit_cell_two && cell_two_wr_ok;

   // The strobe is taken only in manual mode and is never stored.
   wire restart_fire = wr_fire && hit_switch && pstrb[1] &&
                       pwdata[RESTART_BIT] && mode_manual;

   ////////////////////////////////////////////////////////////////////////////////
   // Byte-lane merge; the masks keep unused bits at zero.
   assign wd16 = pwdata[15:0];
   assign strb16 = pstrb[1:0];
   assign aux_word = {aux_diag_select_r, 13'h0000};
   assign switch_word = {2'h0, balance_switch_enable_r};
   assign group_word = {6'h00, group_expiry_time_r};
   assign cell_two_word = {6'h00, cell_two_expiry_time_r};
   assign aux_merge = merge16(aux_word, wd16, strb16, MASK_AUX_DIAG);
   assign switch_merge = merge16(switch_word, wd16, strb16, MASK_SWITCH);
   assign group_merge = merge16(group_word, wd16, strb16, MASK_EXPIRY);
   assign cell_two_merge = merge16(cell_two_word, wd16, strb16, MASK_EXPIRY);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_diag_select_r <= RST_AUX_SEL;
         balance_switch_enable_r <= RST_SWITCH_EN;
         group_expiry_time_r <= RST_EXPIRY;
         cell_two_expiry_time_r <= RST_EXPIRY;
      end else if (clk_en) begin
         if (wr_aux) begin
            aux_diag_select_r <= aux_merge[15:AUX_SEL_LSB];
         end
         if (wr_switch) begin
            balance_switch_enable_r <= switch_merge[13:0];
         end
         if (wr_group) begin
            group_expiry_time_r <= group_merge[9:0];
         end
         if (wr_cell_two) begin
            cell_two_expiry_time_r <= cell_two_merge[9:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path; the restart bit always reads zero.
   assign read_val = hit_aux ? {16'h0000, aux_word} :
                     hit_switch ? {16'h0000, switch_word} :
                     hit_group ? {16'h0000, group_word} :
                     hit_cell_two ? {16'h0000, cell_two_word} : 32'h0000_0000;

   // Read data is captured in the setup cycle so that it comes from a flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (clk_en && rd_setup) begin
         prdata_r <= read_val;
      end
   end

   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = access && !hit_any;

   ////////////////////////////////////////////////////////////////////////////////
   balance_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .mode(balance_mode),
      .limit(group_expiry_time_r),
      .arm(balance_control_write),
      .restart(restart_fire),
      .tick_second(tick_second),
      .tick_minute(tick_minute),
      .tick_hour(tick_hour),
      .count_r(timer_count),
      .expired_r(timer_expired)
   );

   aux_diag_decode u_aux (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .aux_diag_select(aux_diag_select_r),
      .aux_port_analog(aux_port_analog),
      .aux_discharge_r(aux_discharge),
      .therm_to_ground_r(therm_to_ground)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Switches follow the enables only while the manual watchdog has not expired;
   // the automated engines outside drive the switches in the other modes.
   assign switch_close = (mode_manual && !timer_expired) ?
                         balance_switch_enable_r : 14'h0000;
   assign balance_timer_expired = timer_expired;
   assign balance_timer = timer_count;
   assign group_limit = (balance_mode != MODE_OFF) ? group_expiry_time_r : EXP_NONE;
   assign cell_two_limit = mode_auto ? cell_two_expiry_time_r : EXP_NONE;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_switch_write_blocked;
      wr_fire && hit_switch && !switch_wr_ok && clk_en;
   endsequence

   sequence s_restart_in_manual;
      restart_fire && !timer_expired && !balance_control_write && clk_en;
   endsequence

   a_switch_write_blocked: assert property (
      s_switch_write_blocked |=> $stable(balance_switch_enable_r))
      else $error("switch enables changed in a blocked mode");

   a_restart_clears_timer: assert property (
      s_restart_in_manual |=> timer_count == 10'h000)
      else $error("restart did not clear the timer");

   a_restart_reads_zero: assert property (
      rd_setup && hit_switch && clk_en |=> prdata[RESTART_BIT] == 1'b0)
      else $error("restart bit read back as one");

   a_restart_outside_manual: assert property (
      !mode_manual |-> !restart_fire)
      else $error("restart taken outside manual mode");

   a_expired_stays: assert property (
      timer_expired && !balance_control_write && clk_en |=> timer_expired)
      else $error("timer left expiry without a new arm");

   a_switch_follow: assert property (
      mode_manual && !timer_expired |-> switch_close == balance_switch_enable_r)
      else $error("switch outputs do not follow enables");

   a_group_write_blocked: assert property (
      wr_fire && hit_group && balance_mode != MODE_OFF && clk_en
      |=> $stable(group_expiry_time_r))
      else $error("group expiry changed while balancing");

   a_forever_no_expiry: assert property (
      group_expiry_time_r == EXP_FOREVER && $stable(group_expiry_time_r) && !timer_expired
      |=> !timer_expired)
      else $error("timer expired with infinite expiry");

   a_zero_is_expired: assert property (
      group_expiry_time_r == EXP_NONE && clk_en ##1 group_expiry_time_r == EXP_NONE
      |-> timer_expired && switch_close == 14'h0000)
      else $error("zero expiry did not count as expired");

   a_cell_two_blocked: assert property (
      wr_fire && hit_cell_two && mode_auto && clk_en |=> $stable(cell_two_expiry_time_r))
      else $error("cell two expiry changed in automated mode");

   a_cell_two_gated: assert property (
      !mode_auto |-> cell_two_limit == EXP_NONE)
      else $error("cell two expiry used outside automated modes");

   a_aux_only_analog: assert property (
      $past(clk_en) |-> (aux_discharge & ~$past(aux_port_analog)) == 6'h00)
      else $error("discharge applied to a non analog port");

   a_aux_write_two: assert property (
      wr_aux && strb16[1] && wd16[15:13] == AUX_ACCEL_DISCHARGE && clk_en
      ##1 clk_en ##1 1'b1 |-> aux_discharge == $past(aux_port_analog))
      else $error("accelerated discharge not applied");

   a_unused_zero: assert property (
      rd_setup && clk_en |=> prdata[31:16] == 16'h0000)
      else $error("unused bits read nonzero");

   // The count saturates at the infinite value, so a tick there must not wrap it.
   sequence s_second_tick;
      mode_manual && tick_second && !timer_expired && !balance_control_write &&
      !restart_fire && timer_count != EXP_FOREVER && clk_en;
   endsequence

   a_second_tick_counts: assert property (
      s_second_tick |=> timer_count == $past(timer_count) + 10'h001)
      else $error("second tick not counted in manual mode");

   a_other_units_ignored: assert property (
      mode_manual && !tick_second && !balance_control_write && !restart_fire && clk_en
      |=> $stable(timer_count))
      else $error("timer moved without a second tick");

   a_restart_ignored: assert property (
      wr_fire && hit_switch && pwdata[RESTART_BIT] && !mode_manual &&
      !balance_control_write && clk_en |=> timer_count >= $past(timer_count))
      else $error("restart cleared the timer outside manual mode");

   a_late_restart_ignored: assert property (
      restart_fire && timer_expired && !balance_control_write && clk_en
      |=> timer_expired && $stable(timer_count))
      else $error("restart acted on an expired timer");

   a_switch_open_expired: assert property (
      timer_expired |-> switch_close == 14'h0000)
      else $error("switches closed after the watchdog expired");

   a_switch_write_lands: assert property (
      wr_switch && strb16 == 2'h3 && clk_en
      |=> balance_switch_enable_r == $past(wd16[13:0]))
      else $error("switch enable write lost");

   a_group_write_lands: assert property (
      wr_group && strb16 == 2'h3 && clk_en
      |=> group_expiry_time_r == $past(wd16[9:0]))
      else $error("group expiry write lost in mode 000");

   a_therm_write_two: assert property (
      wr_aux && strb16[1] && wd16[15:13] == AUX_THERM_GROUND && clk_en
      ##1 clk_en ##1 1'b1 |-> therm_to_ground)
      else $error("thermistor bias not tied to ground");

   a_aux_reserved_normal: assert property (
      aux_diag_select_r[2] && clk_en |=> !therm_to_ground && aux_discharge == 6'h00)
      else $error("reserved selector code changed the ports");

   a_unmapped_no_write: assert property (
      access && pwrite && !hit_any && clk_en
      |=> $stable(aux_diag_select_r) && $stable(balance_switch_enable_r) &&
          $stable(group_expiry_time_r) && $stable(cell_two_expiry_time_r))
      else $error("unmapped write changed a register");

endmodule
`default_nettype wire

// *** test_balance_timer_registers.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_balance_timer_registers
   import balance_pkg::*;
();
   logic pclk, presetn, psel, penable, pwrite, bcw;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [2:0] balance_mode, tk;
   logic [5:0] aux_port_analog;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, expired, therm;
   wire logic [13:0] sw;
   wire logic [9:0] timer, glim, clim;
   wire logic [5:0] aux_dis;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;

   balance_timer_registers DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .balance_mode(balance_mode),
      .balance_control_write(bcw), .tick_second(tk[0]), .tick_minute(tk[1]),
      .tick_hour(tk[2]), .aux_port_analog(aux_port_analog), .switch_close(sw),
      .balance_timer_expired(expired), .balance_timer(timer), .group_limit(glim),
      .cell_two_limit(clim), .aux_discharge(aux_dis), .therm_to_ground(therm));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // A hang anywhere in the sequence ends here instead of running forever.
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask

   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      check(what, rd, exp);
   endtask

   // Index 3 is the balancing control write pulse, 0 to 2 the time base ticks.
   task automatic pulse(input int b);
      @(posedge pclk);
      if (b == 3) begin
         bcw <= 1'b1;
      end else begin
         tk[b] <= 1'b1;
      end
      @(posedge pclk);
      bcw <= 1'b0;
      tk <= 3'h0;
   endtask

   task automatic settle();
      repeat (2) @(negedge pclk);
   endtask

   task automatic mode_to(input logic [2:0] m);
      @(posedge pclk);
      balance_mode <= m;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd_chk("aux reset", ADDR_AUX_DIAG, 32'h0);
      rd_chk("switch reset", ADDR_SWITCH, 32'h0);
      rd_chk("group reset", ADDR_EXP_GROUP, 32'h0);
      rd_chk("cell two reset", ADDR_EXP_CELL_TWO, 32'h0);
      check("expired at reset", expired, 1'b1);
   endtask

   task automatic t_aux();
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_AUX_DIAG, {16'h0, c[2:0], 13'h1fff});
         repeat (4) @(negedge pclk);
         rd_chk("aux readback", ADDR_AUX_DIAG, {16'h0, c[2:0], 13'h0});
         check("aux discharge", aux_dis, (c == 2) ? aux_port_analog : 6'h0);
         check("thermistor ground", therm, c == 3);
      end
      wr(ADDR_AUX_DIAG, 32'h4000);
      aux_port_analog <= 6'h12;
      repeat (4) @(negedge pclk);
      check("aux only analog ports", aux_dis, 6'h12);
      wr(ADDR_AUX_DIAG, 32'h0);
   endtask

   task automatic t_switch();
      logic [2:0] blk [5] = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
      foreach (blk[i]) begin
         mode_to(blk[i]);
         wr(ADDR_SWITCH, 32'h0aaa);
         rd_chk("switch blocked", ADDR_SWITCH, 32'h0);
      end
      mode_to(MODE_GROUP);
      wr(ADDR_SWITCH, 32'h7fff);
      rd_chk("switch unused bits", ADDR_SWITCH, 32'h3fff);
      wr(ADDR_SWITCH, 32'h0005);
   endtask

   // A zero limit must never let the switches close, even once armed.
   task automatic t_zero();
      mode_to(MODE_MANUAL);
      pulse(3);
      pulse(0);
      settle();
      check("zero limit expired", expired, 1'b1);
      check("zero limit switches", sw, 14'h0);
   endtask

   task automatic t_group();
      mode_to(MODE_OFF);
      wr(ADDR_EXP_GROUP, 32'hffff);
      rd_chk("group unused bits", ADDR_EXP_GROUP, 32'h3ff);
      wr(ADDR_EXP_GROUP, 32'h2);
      mode_to(MODE_DISCHARGE);
      wr(ADDR_EXP_GROUP, 32'h7);
      rd_chk("group blocked discharge", ADDR_EXP_GROUP, 32'h2);
      check("group limit out", glim, 10'h2);
      mode_to(MODE_GROUP);
      wr(ADDR_EXP_GROUP, 32'h9);
      rd_chk("group blocked group", ADDR_EXP_GROUP, 32'h2);
   endtask

   task automatic t_manual();
      mode_to(MODE_MANUAL);
      pulse(3);
      settle();
      check("armed", expired, 1'b0);
      check("switch close", sw, 14'h5);
      pulse(0);
      settle();
      check("one second", timer, 10'h1);
      wr(ADDR_SWITCH, 32'h8005);
      settle();
      check("restart clears", timer, 10'h0);
      rd_chk("strobe reads zero", ADDR_SWITCH, 32'h5);
      pulse(1);
      pulse(2);
      settle();
      check("wrong unit ignored", timer, 10'h0);
      pulse(0);
      pulse(0);
      settle();
      check("count at limit", timer, 10'h2);
      check("watchdog expired", expired, 1'b1);
      check("switches open", sw, 14'h0);
      wr(ADDR_SWITCH, 32'h8005);
      settle();
      check("late restart", timer, 10'h2);
      check("still expired", expired, 1'b1);
      pulse(3);
      settle();
      check("rearm", expired, 1'b0);
      check("rearm count", timer, 10'h0);
   endtask

   task automatic t_other();
      mode_to(MODE_GROUP);
      pulse(3);
      pulse(1);
      settle();
      check("minute tick", timer, 10'h1);
      wr(ADDR_SWITCH, 32'h8005);
      pulse(0);
      settle();
      check("restart outside manual", timer, 10'h1);
   endtask

   task automatic t_forever();
      mode_to(MODE_OFF);
      wr(ADDR_EXP_GROUP, 32'h3ff);
      mode_to(MODE_MANUAL);
      pulse(3);
      repeat (3) pulse(0);
      settle();
      check("forever count", timer, 10'h3);
      check("forever active", expired, 1'b0);
   endtask

   task automatic t_cell_two();
      logic [31:0] rd;
      logic err;
      mode_to(MODE_OFF);
      wr(ADDR_EXP_CELL_TWO, 32'h155);
      rd_chk("cell two write", ADDR_EXP_CELL_TWO, 32'h155);
      check("cell two unused mode", clim, 10'h0);
      mode_to(3'h4);
      settle();
      check("cell two individual", clim, 10'h155);
      wr(ADDR_EXP_CELL_TWO, 32'h0aa);
      rd_chk("cell two blocked", ADDR_EXP_CELL_TWO, 32'h155);
      mode_to(MODE_GROUP);
      wr(ADDR_EXP_CELL_TWO, 32'hffff);
      rd_chk("cell two unused bits", ADDR_EXP_CELL_TWO, 32'h3ff);
      apb(1'b1, 12'h000, 32'hffff, rd, err);
      check("unmapped write error", err, 1'b1);
      apb(1'b0, 12'h000, 32'h0, rd, err);
      check("unmapped error", err, 1'b1);
      check("unmapped data", rd, 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      bcw = 1'b0;
      tk = 3'h0;
      balance_mode = MODE_OFF;
      aux_port_analog = 6'h2d;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_aux();
      t_switch();
      t_zero();
      t_group();
      t_manual();
      t_other();
      t_forever();
      t_cell_two();
      give_verdict();
   end
endmodule
`default_nettype wire
